//--- bench/usart_sync_slave_transmit_tb.sv
// Testbench of the slave transmitter: bus tasks, word queue, verdict.
// Assumes uss_ext_master supplies the shift clock from outside.
`timescale 1ns/1ns
`include "uss_map.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module usart_sync_slave_transmit_tb;
  logic        core_clk, arst_n, avs_read, avs_write, sleep_mode;
  logic [7:0]  avs_address, q, d;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, wake_req, irq_vector;
  wire         shift_clock_pin, data_pin_out, data_pin_oe;
  int          n_errors, checked, seed;
  logic [8:0]  w;
  logic [8:0]  exp_q[$];

  // ==========================================================================
  // Clock, design and far side
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  uss_transmit dut (.core_clk(core_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_mode(sleep_mode), .wake_req(wake_req), .irq_vector(irq_vector),
    .shift_clock_pin(shift_clock_pin), .data_pin_out(data_pin_out),
    .data_pin_oe(data_pin_oe));
  uss_ext_master pm (.shift_clock_pin(shift_clock_pin),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe));

  // ==========================================================================
  // Tasks
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
    int n;
    @(posedge core_clk);
    avs_address   <= a;
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {24'h0, v};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("unexpected waitrequest exp 0 got %b", avs_waitrequest);
    end
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Clocks one word out and compares it with the model's head
  task automatic send(input int nb);
    logic [8:0] m;
    pm.clock_word(nb, w);
    m = exp_q.pop_front();
    `CHK("word", m, w)
    repeat (10) @(posedge core_clk);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog, well past the expected run of some 800 cycles
  initial begin
    #600000;
    n_errors++;
    stop_test;
  end

  // Main sequence
  initial begin
    seed = 49149;
    n_errors = 0;
    checked = 0;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    sleep_mode = 1'b0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    bus(1'b0, `USS_OFS_TX_SC, 8'h00);
    `CHK("tx_sc", `USS_RST_TX_SC, q & `USS_WMASK_TX_SC)
    bus(1'b0, `USS_OFS_PFLAG1, 8'h00);
    `CHK("flag_rst", 8'h10, q & 8'h10)
    bus(1'b0, 8'h1c, 8'h00);
    `CHK("unmapped", 8'h00, q)
    // Master select set: transmitter must stay off
    bus(1'b1, `USS_OFS_RX_SC, 8'h80);
    bus(1'b1, `USS_OFS_TX_SC, 8'hb0);
    repeat (4) @(posedge core_clk);
    `CHK("oe_master", 1'b0, data_pin_oe)
    bus(1'b1, `USS_OFS_TX_SC, 8'h30);
    // Low byte disabled: this write must leave the mode alone
    avs_byteenable <= 4'h0;
    bus(1'b1, `USS_OFS_TX_SC, 8'h00);
    avs_byteenable <= 4'h1;
    bus(1'b0, `USS_OFS_TX_SC, 8'h00);
    `CHK("tx_sc_kept", 8'h30, q & `USS_WMASK_TX_SC)
    repeat (4) @(posedge core_clk);
    `CHK("oe_slave", 1'b1, data_pin_oe)
    bus(1'b1, `USS_OFS_INT_CTL, 8'hc0);
    bus(1'b1, `USS_OFS_PEN1, 8'h10);
    // Two words loaded, then sleep
    for (int k = 0; k < 2; k++) begin
      d = $random(seed);
      exp_q.push_back({1'b0, d});
      bus(1'b1, `USS_OFS_TX_BUF, d);
    end
    sleep_mode <= 1'b1;
    bus(1'b0, `USS_OFS_PFLAG1, 8'h00);
    `CHK("flag_held", 8'h00, q & 8'h10)
    `CHK("wake_early", 1'b0, wake_req)
    send(8);
    bus(1'b0, `USS_OFS_PFLAG1, 8'h00);
    `CHK("flag_set", 8'h10, q & 8'h10)
    `CHK("wake", 1'b1, wake_req)
    `CHK("irq", 1'b1, irq_vector)
    send(8);
    // Interrupt enable cleared: no wake in sleep
    bus(1'b1, `USS_OFS_PEN1, 8'h00);
    repeat (3) @(posedge core_clk);
    `CHK("wake_masked", 1'b0, wake_req)
    sleep_mode <= 1'b0;
    // Nine-bit words while awake, both ninth values
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      bus(1'b1, `USS_OFS_TX_SC, {7'h38, k[0]});
      exp_q.push_back({k[0], d});
      bus(1'b1, `USS_OFS_TX_BUF, d);
      send(9);
    end
    stop_test;
  end
endmodule // usart_sync_slave_transmit_tb

bind uss_transmit uss_transmit_assertions #(.ADDR_W(ADDR_W)) chk (
  .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
  .wake_req(wake_req), .irq_vector(irq_vector),
  .shift_clock_pin(shift_clock_pin), .data_pin_out(data_pin_out),
  .data_pin_oe(data_pin_oe));

//--- bench/uss_ext_master.sv
// External master that clocks words out of the slave transmitter.
// Assumes the clock pin idles high and each bit is read at its fall.
`timescale 1ns/1ns

module uss_ext_master (
  output logic shift_clock_pin,
  input  wire  data_pin_out,
  input  wire  data_pin_oe
);
  // ==========================================================================
  // Clock stands high between frames, never runs free
  initial shift_clock_pin = 1'b1;

  // One pulse per bit at 125 ns; bit read just before the fall
  task automatic clock_word(input int nb, output logic [8:0] w);
    w = 9'h000;
    for (int i = 0; i < nb; i++) begin
      #62;
      // An undriven line floats; its inverse makes a dropped enable show
      w[i] = data_pin_oe ? data_pin_out : ~data_pin_out;
      shift_clock_pin = 1'b0;
      #63;
      shift_clock_pin = 1'b1;
    end
  endtask
endmodule // uss_ext_master

//--- bench/uss_transmit_assertions.sv
// Checker for the slave transmitter's bus answer and pin timing.
// Assumes it is bound to uss_transmit and sees only its ports.
`timescale 1ns/1ns

module uss_transmit_assertions #(
  parameter ADDR_W = 8
) (
  input wire              core_clk,
  input wire              arst_n,
  input wire [ADDR_W-1:0] avs_address,
  input wire              avs_read,
  input wire              avs_write,
  input wire [31:0]       avs_writedata,
  input wire [3:0]        avs_byteenable,
  input wire [31:0]       avs_readdata,
  input wire              avs_waitrequest,
  input wire              sleep_mode,
  input wire              wake_req,
  input wire              irq_vector,
  input wire              shift_clock_pin,
  input wire              data_pin_out,
  input wire              data_pin_oe
);
  // ==========================================================================
  // Event ages
  logic       pin_q;
  logic [3:0] fall_age;
  logic [3:0] wr_age;

  // Ages saturate so long idle spells stay quiet
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q    <= 1'b1;
      fall_age <= 4'hf;
      wr_age   <= 4'hf;
    end else begin
      pin_q    <= shift_clock_pin;
      fall_age <= (pin_q && !shift_clock_pin) ? 4'h0 :
                  (fall_age == 4'hf) ? fall_age : fall_age + 4'h1;
      wr_age   <= (avs_write && !avs_waitrequest) ? 4'h0 :
                  (wr_age == 4'hf) ? wr_age : wr_age + 4'h1;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence answer_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (taken_s |=> answer_s)
    else $error("bus answer not a single cycle");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  read_hold_a: assert property ($changed(avs_readdata) |->
    $past(avs_read) && $past(avs_waitrequest))
    else $error("read data moved without a read");
  data_cause_a: assert property ($changed(data_pin_out) |->
    fall_age <= 4'h6 || wr_age <= 4'h3)
    else $error("data pin moved without a clock fall");
  oe_cause_a: assert property ($changed(data_pin_oe) |-> wr_age <= 4'h3)
    else $error("output enable moved without a write");
  wake_sleep_a: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake request outside sleep");
  irq_wake_a: assert property (irq_vector && $past(sleep_mode) |->
    wake_req)
    else $error("interrupt in sleep without wake");
  irq_cause_a: assert property ($rose(irq_vector) |->
    wr_age <= 4'h4 || fall_age <= 4'h8)
    else $error("interrupt rose without a load");
endmodule // uss_transmit_assertions

//--- common/uss_map.vh
// Register map, field positions and reset values of the slave transmitter.
// Assumes a 32-bit Avalon-MM bus with byte addresses, one word per register.
`ifndef USS_MAP_VH
`define USS_MAP_VH

// ==========================================================================
// Register byte offsets
`define USS_OFS_INT_CTL   8'h00
`define USS_OFS_PFLAG1    8'h04
`define USS_OFS_PEN1      8'h08
`define USS_OFS_RX_SC     8'h0c
`define USS_OFS_TX_SC     8'h10
`define USS_OFS_TX_BUF    8'h14
`define USS_OFS_RX_BUF    8'h18

// ==========================================================================
// Interrupt control fields
`define USS_INT_GIE       7
`define USS_INT_PERIPHERAL_INTERRUPT_ENABLE      6

// Peripheral flag and enable fields
`define USS_PF1_TXIF      4
`define USS_PE1_TXIE      4

// Receive status and control fields
`define USS_RX_PORT_ENABLE       7
`define USS_RX_SINGLE_RECEIVE_ENABLE       5
`define USS_RX_CONTINUOUS_RECEIVE_ENABLE       4

// Transmit status and control fields
`define USS_TX_CLOCK_SOURCE_MASTER_SELECT       7
`define USS_TX_TX9        6
`define USS_TX_TRANSMIT_ENABLE       5
`define USS_TX_SYNC       4
`define USS_TX_TRMT       1
`define USS_TX_TRANSMIT_NINTH_BIT       0

// ==========================================================================
// Reset values and writable masks
`define USS_RST_INT_CTL   8'h00
`define USS_RST_PEN1      8'h00
`define USS_RST_RX_SC     8'h00
`define USS_RST_TX_SC     8'h00
`define USS_RST_TX_BUF    8'h00
`define USS_WMASK_RX_SC   8'hf8
`define USS_WMASK_TX_SC   8'hfd

// Bits per word
`define USS_BITS_8        4'h8
`define USS_BITS_9        4'h9

`endif

//--- logic/uss_sync2.v
// Two-stage synchroniser for levels entering the core clock domain.
// Assumes the input is a slow level; only the second stage is read.
`timescale 1ns/1ns

module uss_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // ========================================================================
  // Stage one feeds stage two and nothing else
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // uss_sync2

//--- logic/uss_transmit.v
// Synchronous slave transmit path of a serial port, with its registers.
// Assumes an Avalon-MM master on core_clk and an external master that
// drives the shift clock pin; pin inputs are asynchronous to core_clk.
//
// Behaviour
// RULE1: Slave mode is active when clocked mode is on and master select is 0.
// RULE2: The shift clock is taken from the clock pin, never generated here.
// RULE3: Shifting continues regardless of the core's low-power state.
// RULE4: Transmission runs the same way in and out of sleep.
// RULE5: A buffered word moves at once into the idle shift register.
// RULE6: A second word waits in the buffer while the first shifts out.
// RULE7: The buffer free flag stays low while a word waits in the buffer.
// RULE8: After the last bit the waiting word moves in and the flag rises.
// RULE9: With the interrupt enable set, a free buffer in sleep wakes the chip.
// RULE10: With global interrupts on, the interrupt requests the vector.
// RULE11: Software sets clocked mode and port enable and clears master select.
// RULE12: Software clears both receive enables before transmitting.
// RULE13: For nine bits software sets nine-bit select and loads the ninth bit.
// RULE14: With transmit enabled, loading the buffer starts a transmission.
// RULE15: Software sets global and peripheral enables at bits 7:6.
// RULE16: The external master gives one clock pulse per bit of each word.
// RULE17: Bits leave LSB first, one per external clock pulse.
`timescale 1ns/1ns
`include "uss_map.vh"

module uss_transmit #(
  parameter ADDR_W = 8
) (
  input  wire              core_clk,
  input  wire              arst_n,
  // Avalon-MM slave
  input  wire [ADDR_W-1:0] avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  input  wire [3:0]        avs_byteenable,
  output wire [31:0]       avs_readdata,
  output wire              avs_waitrequest,
  // Core power state and interrupt requests
  input  wire              sleep_mode,
  output wire              wake_req,
  output wire              irq_vector,
  // Serial pins
  input  wire              shift_clock_pin,
  output wire              data_pin_out,
  output wire              data_pin_oe
);

  // ========================================================================
  // Declarations
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  // Shift state and bus answer
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         wait_reg;
  reg  [31:0] rdata_reg;
  // Software-visible registers
  reg  [7:0]  int_ctl_reg;
  reg  [7:0]  pen1_reg;
  reg  [7:0]  rx_sc_reg;
  reg  [7:0]  tx_sc_reg;
  // Transmit buffer and shift register
  reg  [7:0]  buf_data_reg;
  reg         buf_ninth_reg;
  reg         buf_full_reg;
  reg         buf_full_next;
  reg  [8:0]  tsr_reg;
  reg  [8:0]  tsr_next;
  reg  [3:0]  bits_left_reg;
  reg  [3:0]  bits_left_next;
  // Pin edge, pin drive and requests
  reg         ck_prev_reg;
  reg         oe_reg;
  reg         wake_reg;
  reg         vec_reg;
  // Combinational helpers
  reg  [7:0]  rd_mux;
  wire        ck_sync;
  wire        ck_fall;
  wire        slave_on;
  wire        take_word;
  wire        bus_req;
  wire        wr_go;
  wire        tx_busy;
  wire        buf_free;

  // ========================================================================
  // Clock pin synchroniser
  // The pin is asynchronous; two stages stand before any logic reads it
  uss_sync2 #(
    .WIDTH    (1)
  ) u_ck_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (shift_clock_pin),
    .sync_out (ck_sync)
  );

  // Edge finder runs after both stages
  // A zero reset value can never fake a fall, whatever the pin does
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_prev_reg <= 1'b0;
    end else begin
      ck_prev_reg <= ck_sync;
    end
  end

  // External master samples on its falling edge, so we move on after it
  assign ck_fall = ck_prev_reg & ~ck_sync; // RULE2

  // ========================================================================
  // Mode decode
  // Master clocking is not built here; with master select set, we stay idle
  // Receive enables are stored but unused: this path only transmits
  assign slave_on = rx_sc_reg[`USS_RX_PORT_ENABLE] &
                    tx_sc_reg[`USS_TX_SYNC] &
                    ~tx_sc_reg[`USS_TX_CLOCK_SOURCE_MASTER_SELECT] & // RULE1
                    tx_sc_reg[`USS_TX_TRANSMIT_ENABLE];   // RULE14

  assign tx_busy  = state_reg[1];
  assign buf_free = ~buf_full_reg;

  // ========================================================================
  // Avalon-MM handshake
  // One wait cycle, then a single cycle with waitrequest low
  // The write lands on the edge that ends the low cycle, so the master
  // must hold address and data until it sees waitrequest low
  assign bus_req = avs_read | avs_write;
  assign wr_go   = avs_write & ~wait_reg & avs_byteenable[0];

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 1'b1;
    end else if (bus_req && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read data mux; unmapped and write-only words read as zero
  // Buffer words fall to the default; software cannot read back a load
  always @* begin
    rd_mux = 8'h00;
    case (avs_address)
      `USS_OFS_INT_CTL: begin
        rd_mux = int_ctl_reg;
      end
      `USS_OFS_PFLAG1: begin
        rd_mux[`USS_PF1_TXIF] = buf_free;
      end
      `USS_OFS_PEN1: begin
        rd_mux = pen1_reg;
      end
      `USS_OFS_RX_SC: begin
        rd_mux = rx_sc_reg;
      end
      `USS_OFS_TX_SC: begin
        rd_mux = tx_sc_reg;
        rd_mux[`USS_TX_TRMT] = ~tx_busy;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Read data is captured on the edge that drops waitrequest
  // Held between reads; writes never disturb it
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && wait_reg) begin
      rdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  // ========================================================================
  // Control registers
  // Software sets up mode, enables and receive bits; checked only by use
  // Unmapped offsets fall to the default and change nothing
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_ctl_reg <= `USS_RST_INT_CTL;
      pen1_reg    <= `USS_RST_PEN1;
      rx_sc_reg   <= `USS_RST_RX_SC;
      tx_sc_reg   <= `USS_RST_TX_SC;
    end else if (wr_go) begin
      case (avs_address)
        `USS_OFS_INT_CTL: begin
          int_ctl_reg <= avs_writedata[7:0]; // RULE15
        end
        `USS_OFS_PEN1: begin
          pen1_reg <= avs_writedata[7:0];
        end
        `USS_OFS_RX_SC: begin
          rx_sc_reg <= avs_writedata[7:0] & `USS_WMASK_RX_SC; // RULE12
        end
        `USS_OFS_TX_SC: begin
          tx_sc_reg <= avs_writedata[7:0] & `USS_WMASK_TX_SC; // RULE11
        end
        default: begin
          int_ctl_reg <= int_ctl_reg;
        end
      endcase
    end
  end

  // ========================================================================
  // Transmit buffer
  // The ninth bit is caught with the word, so it must be written first
  // Writing while full overwrites the waiting word without warning
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_data_reg  <= `USS_RST_TX_BUF;
      buf_ninth_reg <= 1'b0;
    end else if (wr_go && avs_address == `USS_OFS_TX_BUF) begin
      buf_data_reg  <= avs_writedata[7:0];
      buf_ninth_reg <= tx_sc_reg[`USS_TX_TRANSMIT_NINTH_BIT]; // RULE13
    end
  end

  // Word moves to the shift register when it is empty or just finishing
  assign take_word = buf_full_reg & slave_on &
                     (state_reg[0] | (ck_fall && bits_left_reg == 4'h1));

  // A load in the same cycle as a transfer wins: the new word is kept
  always @* begin
    buf_full_next = buf_full_reg;
    if (take_word) begin
      buf_full_next = 1'b0; // RULE8
    end
    if (wr_go && avs_address == `USS_OFS_TX_BUF) begin
      buf_full_next = 1'b1; // RULE14
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_full_reg <= 1'b0;
    end else begin
      buf_full_reg <= buf_full_next; // RULE7
    end
  end

  // ========================================================================
  // Shift machine
  // Runs on the pin's own pulses, so sleep does not stop it
  // The count reaches one on the last bit; the next fall ends the word
  // Word length is fixed at load, so a nine-bit change waits a word
  always @* begin
    state_next     = state_reg;
    tsr_next       = tsr_reg;
    bits_left_next = bits_left_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take_word) begin
          tsr_next       = {buf_ninth_reg, buf_data_reg}; // RULE5
          bits_left_next = tx_sc_reg[`USS_TX_TX9] ? `USS_BITS_9
                                                  : `USS_BITS_8;
          state_next     = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!slave_on) begin
          // Dropping an enable aborts the word in flight
          state_next     = ST_IDLE;
          bits_left_next = 4'h0;
        end else if (ck_fall) begin
          if (bits_left_reg == 4'h1) begin
            if (take_word) begin
              // Back-to-back words with no idle gap
              tsr_next       = {buf_ninth_reg, buf_data_reg}; // RULE8
              bits_left_next = tx_sc_reg[`USS_TX_TX9] ? `USS_BITS_9
                                                      : `USS_BITS_8;
            end else begin
              bits_left_next = 4'h0;
              state_next     = ST_IDLE;
            end
          end else begin
            tsr_next       = {1'b0, tsr_reg[8:1]}; // RULE17
            bits_left_next = bits_left_reg - 4'h1; // RULE6
          end
        end
      end
      default: begin
        state_next     = ST_IDLE;
        bits_left_next = 4'h0;
      end
    endcase
  end

  // Same path in and out of sleep
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= ST_IDLE;
      tsr_reg       <= 9'h000;
      bits_left_reg <= 4'h0;
    end else begin
      state_reg     <= state_next; // RULE3
      tsr_reg       <= tsr_next;   // RULE4
      bits_left_reg <= bits_left_next;
    end
  end

  // ========================================================================
  // Data pin drive
  // The pin is driven whenever the slave transmitter is enabled
  // Limitation: between words the pin keeps showing the last bit sent
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= slave_on;
    end
  end

  assign data_pin_out = tsr_reg[0]; // RULE17
  assign data_pin_oe  = oe_reg;

  // ========================================================================
  // Interrupt requests
  // Wake needs only the local enable; the vector needs both global bits
  // Both are levels that drop as soon as the buffer is loaded again
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_reg <= 1'b0;
      vec_reg  <= 1'b0;
    end else begin
      wake_reg <= sleep_mode & buf_free &
                  pen1_reg[`USS_PE1_TXIE]; // RULE9
      vec_reg  <= buf_free & pen1_reg[`USS_PE1_TXIE] &
                  int_ctl_reg[`USS_INT_PERIPHERAL_INTERRUPT_ENABLE] &
                  int_ctl_reg[`USS_INT_GIE]; // RULE10
    end
  end

  assign wake_req   = wake_reg;
  assign irq_vector = vec_reg;

endmodule // uss_transmit
